// File: inc/qcr_pkg.sv
// constants and carrier types for the quadrature counter register set
package qcr_pkg;

  localparam int ADDR_W = 6;

  // register byte offsets, one aligned word each
  localparam logic [5:0] OFF_STATUS     = 6'h00;
  localparam logic [5:0] OFF_POS_LOW    = 6'h04;
  localparam logic [5:0] OFF_POS_HIGH   = 6'h08;
  localparam logic [5:0] OFF_POS_STAGE  = 6'h0c;
  localparam logic [5:0] OFF_SPD_LOW    = 6'h10;
  localparam logic [5:0] OFF_SPD_HIGH   = 6'h14;
  localparam logic [5:0] OFF_SPD_STAGE  = 6'h18;
  localparam logic [5:0] OFF_INT_LOW    = 6'h1c;
  localparam logic [5:0] OFF_INT_HIGH   = 6'h20;
  localparam logic [5:0] OFF_ISTG_LOW   = 6'h24;
  localparam logic [5:0] OFF_ISTG_HIGH  = 6'h28;
  localparam logic [5:0] OFF_CONTROL    = 6'h2c;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h30;
  localparam logic [5:0] OFF_IRQ_MASK   = 6'h34;

  // event status field positions
  localparam int ST_INDEX_EN  = 0;
  localparam int ST_INDEX_FLG = 1;
  localparam int ST_HOME_EN   = 2;
  localparam int ST_HOME_FLG  = 3;
  localparam int ST_HOMING_EN = 6;
  localparam int ST_HOMING_FLG = 7;

  // interrupt pending / mask field positions
  localparam int IRQ_INDEX  = 0;
  localparam int IRQ_HOME   = 1;
  localparam int IRQ_HOMING = 2;
  localparam int IRQ_W      = 3;

  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_HOME_A = 3'h3;
  localparam logic [2:0] MODE_HOME_B = 3'h4;

  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic              hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic              hready;
  } ahb_req_t;

  typedef struct packed {
    logic step;
    logic dir_up;
    logic index;
    logic home;
    logic homing_done;
  } enc_evt_t;

endpackage

// File: logic/quadrature_counter_register_set.sv
// quadrature counter register set with AHB-Lite slave and interrupt logic
`timescale 1ns/1ps
module quadrature_counter_register_set #(
  parameter bit SPEED_WIDE = 1'b1
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  input  wire qcr_pkg::ahb_req_t ahb_req_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire qcr_pkg::enc_evt_t enc_evt_i,
  output logic [31:0]           hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  output logic                  irq_o,
  output logic [31:0]           position_count_o
);

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  // assert at once, release two edges later so no flop leaves reset early
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  ////////////////////////////////////////////////////////////////////////
  // bus address and data phase
  logic                       take;
  logic                       ap_valid_q;
  logic                       ap_write_q;
  logic [qcr_pkg::ADDR_W-1:0] ap_addr_q;
  logic                       wr_en;
  logic                       rd_en;
  logic [15:0]                wd;

  // only a selected NONSEQ with the bus ready starts a transfer
  assign take  = ahb_req_i.hsel && ahb_req_i.hready &&
                 (ahb_req_i.htrans == qcr_pkg::HTRANS_NONSEQ);
  assign wr_en = ap_valid_q && ap_write_q;
  assign rd_en = ap_valid_q && !ap_write_q;
  // registers are 16 bits wide; upper write data is ignored
  assign wd    = hwdata_i[15:0];

  function automatic logic hit(input logic en,
                               input logic [5:0] a,
                               input logic [5:0] off);
    hit = en && (a == off);
  endfunction

  // the address phase is captured only while the bus is ready
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= '0;
    end else begin
      if (ahb_req_i.hready) begin
        ap_valid_q <= take;
        ap_write_q <= ahb_req_i.hwrite;
        ap_addr_q  <= {ahb_req_i.haddr[5:2], 2'b00};
      end else begin
        ap_valid_q <= ap_valid_q && ap_write_q;
      end
      if (rd_en) begin
        ap_valid_q <= 1'b0;
      end
    end
  end

  // reads insert one wait cycle so a preceding write has landed
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_o <= 1'b1;
    end else if (take && !ahb_req_i.hwrite) begin
      hreadyout_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
    end
  end

  // every transfer ends with an okay response
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hresp_o <= qcr_pkg::HRESP_OKAY;
    end else begin
      hresp_o <= qcr_pkg::HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and event status
  logic [qcr_pkg::MODE_W-1:0] mode_q;
  logic index_en_q;
  logic home_en_q;
  logic homing_en_q;
  logic index_flg_q;
  logic home_flg_q;
  logic homing_flg_q;
  logic homing_ev;
  logic st_wr;

  assign st_wr = hit(wr_en, ap_addr_q, qcr_pkg::OFF_STATUS);
  // homing completion counts only in the two homing modes
  assign homing_ev = enc_evt_i.homing_done &&
                     ((mode_q == qcr_pkg::MODE_HOME_A) ||
                      (mode_q == qcr_pkg::MODE_HOME_B));

  // control keeps only the position init mode field
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= '0;
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_CONTROL)) begin
      mode_q <= wd[qcr_pkg::MODE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      index_en_q  <= 1'b0;
      home_en_q   <= 1'b0;
      homing_en_q <= 1'b0;
    end else if (st_wr) begin
      index_en_q  <= wd[qcr_pkg::ST_INDEX_EN];
      home_en_q   <= wd[qcr_pkg::ST_HOME_EN];
      homing_en_q <= wd[qcr_pkg::ST_HOMING_EN];
    end
  end

  // a flag clears when software writes zero to it; a new event wins
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      index_flg_q  <= 1'b0;
      home_flg_q   <= 1'b0;
      homing_flg_q <= 1'b0;
    end else begin
      if (enc_evt_i.index) begin
        index_flg_q <= 1'b1;
      end else if (st_wr && !wd[qcr_pkg::ST_INDEX_FLG]) begin
        index_flg_q <= 1'b0;
      end
      if (enc_evt_i.home) begin
        home_flg_q <= 1'b1;
      end else if (st_wr && !wd[qcr_pkg::ST_HOME_FLG]) begin
        home_flg_q <= 1'b0;
      end
      if (homing_ev) begin
        homing_flg_q <= 1'b1;
      end else if (st_wr && !wd[qcr_pkg::ST_HOMING_FLG]) begin
        homing_flg_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt pending, mask and line
  logic [qcr_pkg::IRQ_W-1:0] pend_q;
  logic [qcr_pkg::IRQ_W-1:0] pend_set;
  logic [qcr_pkg::IRQ_W-1:0] pend_d;
  logic [qcr_pkg::IRQ_W-1:0] mask_q;
  logic                      pend_rd;

  assign pend_rd = hit(rd_en, ap_addr_q, qcr_pkg::OFF_IRQ_STATUS);

  // a read clears pending; an event in the same cycle wins
  always_comb begin
    pend_set = '0;
    pend_set[qcr_pkg::IRQ_INDEX]  = enc_evt_i.index && index_en_q;
    pend_set[qcr_pkg::IRQ_HOME]   = enc_evt_i.home && home_en_q;
    pend_set[qcr_pkg::IRQ_HOMING] = homing_ev && homing_en_q;
    pend_d = pend_q;
    if (pend_rd) begin
      pend_d = '0;
    end
    pend_d = pend_d | pend_set;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_IRQ_MASK)) begin
      mask_q <= hwdata_i[qcr_pkg::IRQ_W-1:0];
    end
  end

  // the next pending value is used so irq moves with pending
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(pend_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // position counter and staging
  logic [31:0] pos_q;
  logic [15:0] pos_stage_q;
  logic        pos_lo_rd;

  assign pos_lo_rd = hit(rd_en, ap_addr_q, qcr_pkg::OFF_POS_LOW);

  // a bus write wins over a step in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= '0;
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_POS_LOW)) begin
      pos_q <= {pos_stage_q, wd};
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_POS_HIGH)) begin
      pos_q[31:16] <= wd;
    end else if (enc_evt_i.step) begin
      pos_q <= enc_evt_i.dir_up ? pos_q + 32'h1 : pos_q - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pos_stage_q <= qcr_pkg::WORD_RST;
    end else if (pos_lo_rd) begin
      pos_stage_q <= pos_q[31:16];
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_POS_STAGE)) begin
      pos_stage_q <= wd;
    end
  end

  // registered copy of the counter, one cycle behind
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      position_count_o <= '0;
    end else begin
      position_count_o <= pos_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // speed counter; upper half only when the wide variant is built
  logic [31:0] spd_q;
  logic [15:0] spd_stage_q;
  logic [15:0] spd_hi_mask;
  logic        spd_lo_rd;

  assign spd_hi_mask = SPEED_WIDE ? 16'hffff : 16'h0000;
  assign spd_lo_rd   = hit(rd_en, ap_addr_q, qcr_pkg::OFF_SPD_LOW);

  // as for position, a bus write wins over a step
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spd_q <= '0;
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_SPD_LOW)) begin
      spd_q <= {spd_stage_q & spd_hi_mask, wd};
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_SPD_HIGH)) begin
      spd_q[31:16] <= wd & spd_hi_mask;
    end else if (enc_evt_i.step) begin
      spd_q <= enc_evt_i.dir_up ? spd_q + 32'h1 : spd_q - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spd_stage_q <= qcr_pkg::WORD_RST;
    end else if (spd_lo_rd) begin
      spd_stage_q <= spd_q[31:16] & spd_hi_mask;
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_SPD_STAGE)) begin
      spd_stage_q <= wd & spd_hi_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interval timer: counts clocks between steps, captured on each step
  logic [31:0] itmr_q;
  logic [31:0] istg_q;

  // a bus write wins over the running count
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      itmr_q <= '0;
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_INT_LOW)) begin
      itmr_q[15:0] <= wd;
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_INT_HIGH)) begin
      itmr_q[31:16] <= wd;
    end else if (enc_evt_i.step) begin
      itmr_q <= '0;
    end else begin
      itmr_q <= itmr_q + 32'h1;
    end
  end

  // a step captures the elapsed interval into staging
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      istg_q <= '0;
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_ISTG_LOW)) begin
      istg_q[15:0] <= wd;
    end else if (hit(wr_en, ap_addr_q, qcr_pkg::OFF_ISTG_HIGH)) begin
      istg_q[31:16] <= wd;
    end else if (enc_evt_i.step) begin
      istg_q <= itmr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data
  logic [15:0] rd_word;

  // registers sit in the low half; the upper half reads zero
  always_comb begin
    rd_word = 16'h0000;
    case (ap_addr_q)
      qcr_pkg::OFF_STATUS: begin
        rd_word[qcr_pkg::ST_INDEX_EN]   = index_en_q;
        rd_word[qcr_pkg::ST_INDEX_FLG]  = index_flg_q;
        rd_word[qcr_pkg::ST_HOME_EN]    = home_en_q;
        rd_word[qcr_pkg::ST_HOME_FLG]   = home_flg_q;
        rd_word[qcr_pkg::ST_HOMING_EN]  = homing_en_q;
        rd_word[qcr_pkg::ST_HOMING_FLG] = homing_flg_q;
      end
      qcr_pkg::OFF_POS_LOW:    rd_word = pos_q[15:0];
      qcr_pkg::OFF_POS_HIGH:   rd_word = pos_q[31:16];
      qcr_pkg::OFF_POS_STAGE:  rd_word = pos_stage_q;
      qcr_pkg::OFF_SPD_LOW:    rd_word = spd_q[15:0];
      qcr_pkg::OFF_SPD_HIGH:   rd_word = spd_q[31:16] & spd_hi_mask;
      qcr_pkg::OFF_SPD_STAGE:  rd_word = spd_stage_q;
      qcr_pkg::OFF_INT_LOW:    rd_word = itmr_q[15:0];
      qcr_pkg::OFF_INT_HIGH:   rd_word = itmr_q[31:16];
      qcr_pkg::OFF_ISTG_LOW:   rd_word = istg_q[15:0];
      qcr_pkg::OFF_ISTG_HIGH:  rd_word = istg_q[31:16];
      qcr_pkg::OFF_CONTROL:    rd_word = {13'h0000, mode_q};
      qcr_pkg::OFF_IRQ_STATUS: rd_word = {13'h0000, pend_q};
      qcr_pkg::OFF_IRQ_MASK:   rd_word = {13'h0000, mask_q};
      default:                 rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_o <= '0;
    end else if (rd_en) begin
      hrdata_o <= {16'h0000, rd_word};
    end
  end

endmodule

// File: tb/enc_model.sv
// encoder stand-in that drives one-cycle event pulses
`timescale 1ns/1ps
module enc_model (
  input  wire logic         clk_i,
  output qcr_pkg::enc_evt_t evt_o
);
  initial evt_o = '0;
  // pulse stands for exactly one edge, then the line returns low
  task automatic pulse(input qcr_pkg::enc_evt_t e);
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= '0;
  endtask
endmodule

// File: tb/qcr_assertions.sv
// port-level checks for the quadrature counter register set
`timescale 1ns/1ps
module qcr_checker (
  input wire logic              ref_clk_i,
  input wire logic              rstn_i,
  input wire qcr_pkg::ahb_req_t ahb_req_i,
  input wire qcr_pkg::enc_evt_t enc_evt_i,
  input wire logic [31:0]       hrdata_o,
  input wire logic              hreadyout_o,
  input wire logic              hresp_o,
  input wire logic              irq_o,
  input wire logic [31:0]       position_count_o
);
  logic tk;
  logic ev;
  logic wr_q;
  logic rd_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  assign tk = ahb_req_i.hsel & ahb_req_i.hready &
              (ahb_req_i.htrans == qcr_pkg::HTRANS_NONSEQ);
  assign ev = enc_evt_i.index | enc_evt_i.home | enc_evt_i.homing_done;
  // marks the first data-phase cycle of a taken transfer
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= tk & ahb_req_i.hwrite;
      rd_q <= tk & ~ahb_req_i.hwrite;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_rd_take; tk && !ahb_req_i.hwrite; endsequence
  sequence s_one_wait; !hreadyout_o ##1 hreadyout_o; endsequence
  property p_resp_okay; hresp_o == qcr_pkg::HRESP_OKAY; endproperty
  a_resp_okay: assert property (p_resp_okay)
    else $error("response not okay");
  property p_wr_nowait; tk && ahb_req_i.hwrite |=> hreadyout_o; endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");
  property p_rd_wait; s_rd_take |=> s_one_wait; endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  property p_rd_upper; rd_q |=> hrdata_o[31:16] == 16'h0000; endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("upper read half not zero");
  property p_rd_hold; !rd_q |=> $stable(hrdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  property p_pos_step;
    enc_evt_i.step && !wr_q |-> ##2 position_count_o ==
      $past(position_count_o) + ($past(enc_evt_i.dir_up, 2) ? 1 : -1);
  endproperty
  a_pos_step: assert property (p_pos_step)
    else $error("position step wrong");
  property p_pos_still;
    !enc_evt_i.step && !wr_q |-> ##2 $stable(position_count_o);
  endproperty
  a_pos_still: assert property (p_pos_still)
    else $error("position moved unasked");
  property p_irq_rise;
    $rose(irq_o) |-> $past(ev) || $past(wr_q) || $past(ev, 2) ||
      $past(wr_q, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("irq rose without cause");
  property p_irq_fall;
    $fell(irq_o) |-> $past(rd_q) || $past(wr_q) || $past(rd_q, 2) ||
      $past(wr_q, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell without access");
endmodule
bind quadrature_counter_register_set qcr_checker u_chk (.ref_clk_i,
  .rstn_i, .ahb_req_i, .enc_evt_i, .hrdata_o, .hreadyout_o, .hresp_o,
  .irq_o, .position_count_o);

// File: tb/tb_top.sv
// self-checking bench for the quadrature counter register set
`timescale 1ns/1ps
module tb_top;
  logic              clk;
  logic              rstn;
  logic              sel;
  logic              wr;
  logic [5:0]        addr;
  logic [1:0]        trans;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic [31:0]       pos;
  logic [31:0]       v;
  logic              rdy;
  logic              resp;
  logic              irq;
  logic [2:0]        size;
  qcr_pkg::ahb_req_t req;
  qcr_pkg::enc_evt_t evt;
  int                num_errors;
  int                total_checks;
  assign req = '{sel, addr, trans, wr, size, rdy};
  quadrature_counter_register_set uut (.ref_clk_i(clk), .rstn_i(rstn),
    .ahb_req_i(req), .hwdata_i(wdata), .enc_evt_i(evt), .hrdata_o(rdata),
    .hreadyout_o(rdy), .hresp_o(resp), .irq_o(irq), .position_count_o(pos));
  enc_model enc (.clk_i(clk), .evt_o(evt));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // bounded wait for the bus ready seen at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 40);
    if (rdy !== 1'b1) begin
      chk("bus ready", 32'h1, {31'h0, rdy});
      end_sim;
    end
  endtask
  task automatic wr32(input logic [5:0] a, input logic [31:0] d);
    sel <= 1'b1;
    addr <= a;
    wr <= 1'b1;
    size <= 3'h2;
    trans <= qcr_pkg::HTRANS_NONSEQ;
    wait_rdy;
    sel <= 1'b0;
    trans <= 2'h0;
    wdata <= d;
    wait_rdy;
  endtask
  task automatic rd32(input logic [5:0] a, output logic [31:0] d);
    sel <= 1'b1;
    addr <= a;
    wr <= 1'b0;
    size <= 3'h2;
    trans <= qcr_pkg::HTRANS_NONSEQ;
    wait_rdy;
    sel <= 1'b0;
    trans <= 2'h0;
    wait_rdy;
    d = rdata;
  endtask
  task automatic rc(input string n, input logic [5:0] a,
                    input logic [31:0] e);
    rd32(a, v);
    chk(n, e, v);
    chk("response", 32'h0, {31'h0, resp});
  endtask
  task automatic irq_is(input string n, input logic e);
    repeat (2) @(posedge clk);
    chk(n, {31'h0, e}, {31'h0, irq});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 14; i++) begin
      if (i == 7) begin
        rd32(qcr_pkg::OFF_INT_LOW, v);
        chk("timer runs", 32'h1, {31'h0, |v});
      end else begin
        rc("reset value", 6'(i * 4), 32'h0);
      end
    end
    wr32(6'h38, 32'hffff);
    rc("unmapped", 6'h38, 32'h0);
    // a NONSEQ without select must be ignored
    addr <= qcr_pkg::OFF_IRQ_MASK;
    wr <= 1'b1;
    trans <= qcr_pkg::HTRANS_NONSEQ;
    @(posedge clk);
    trans <= 2'h0;
    wdata <= 32'h7;
    @(posedge clk);
    rc("unselected", qcr_pkg::OFF_IRQ_MASK, 32'h0);
  endtask
  task automatic t_pos;
    wr32(6'h0c, 32'h1234);
    wr32(6'h04, 32'habcd);
    repeat (2) @(posedge clk);
    chk("position", 32'h1234abcd, pos);
    rc("pos high", 6'h08, 32'h1234);
    wr32(6'h08, 32'h5678);
    wr32(6'h0c, 32'h0);
    rc("pos low", 6'h04, 32'habcd);
    rc("pos latch", 6'h0c, 32'h5678);
  endtask
  task automatic t_step;
    wr32(6'h0c, 32'h0);
    wr32(6'h04, 32'hffff);
    enc.pulse(5'h18);
    enc.pulse(5'h18);
    enc.pulse(5'h10);
    rc("step low", 6'h04, 32'h0);
    rc("step high", 6'h0c, 32'h0001);
    rc("speed step", 6'h10, 32'h0001);
  endtask
  task automatic t_speed;
    wr32(6'h18, 32'h00c3);
    wr32(6'h10, 32'h5a5a);
    rc("speed high", 6'h14, 32'h00c3);
    wr32(6'h14, 32'h0777);
    rc("speed low", 6'h10, 32'h5a5a);
    rc("speed latch", 6'h18, 32'h0777);
  endtask
  task automatic t_interval;
    wr32(6'h24, 32'hbeef);
    wr32(6'h28, 32'h0123);
    rc("istg low", 6'h24, 32'hbeef);
    rc("istg high", 6'h28, 32'h0123);
    wr32(6'h20, 32'h00ab);
    rc("int high", 6'h20, 32'h00ab);
  endtask
  task automatic t_index;
    wr32(6'h34, 32'h7);
    enc.pulse(5'h06);
    irq_is("irq disabled", 1'b0);
    rc("event flags", 6'h00, 32'h000a);
    rc("flags kept", 6'h00, 32'h000a);
    wr32(6'h00, 32'h0001);
    rc("flag clear", 6'h00, 32'h0001);
    wr32(6'h34, 32'h0);
    enc.pulse(5'h04);
    irq_is("irq masked", 1'b0);
    wr32(6'h34, 32'h7);
    irq_is("irq on", 1'b1);
    rc("pending", 6'h30, 32'h1);
    rc("pending clr", 6'h30, 32'h0);
    irq_is("irq off", 1'b0);
    wr32(6'h00, 32'h0004);
    enc.pulse(5'h02);
    irq_is("home irq", 1'b1);
    rc("home flag", 6'h00, 32'h000c);
    rc("home pending", 6'h30, 32'h0002);
  endtask
  task automatic t_homing;
    for (int m = 0; m < 5; m++) begin
      wr32(6'h2c, 32'(m));
      wr32(6'h00, 32'h0040);
      enc.pulse(5'h01);
      rc("homing", 6'h00, (m == 3 || m == 4) ? 32'hc0 : 32'h40);
    end
    irq_is("homing irq", 1'b1);
    rc("homing pending", 6'h30, 32'h4);
    irq_is("homing irq off", 1'b0);
  endtask
  initial begin
    num_errors = 0;
    total_checks = 0;
    rstn = 1'b0;
    sel = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    trans = 2'h0;
    wdata = 32'h0;
    size = 3'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_pos;
    t_step;
    t_speed;
    t_interval;
    t_index;
    t_homing;
    end_sim;
  end
endmodule
